/* File: src/sfsr_dev.sv */
// Device end: command decoding for secreg read, deep sleep and wake.
// Assumes link pins arrive asynchronously; sampled on the system clock.
// Operation
// - Secreg read: 48h, three address, one dummy
// - Secreg data out on falling clock edges
// - Any start byte accepted, no alignment
// - Address advances after each data byte
// - Offset wraps 1FFh to 000h, continues
// - Sleep only through B9h command
// - Deselect means standby unless cycle running or power not in run state
// - Asleep, only wake command is decoded
// - Sleep needs deselect right after bit eight
// - Sleep entered after entry delay elapses
// - Sleep command rejected while cycle runs
// - Power-up always starts in standby
// - Wake: ABh then deselect, wait wake delay
// - ABh plus three dummies returns identifier
// - Identifier repeats until deselect
// - Wake with identifier waits shorter delay
// - Wake ignored while write in progress
// - Write in progress high during cycles
`timescale 1ns/1ns
`default_nettype none
module sfsr_dev
    import sfsr_pkg::*;
#(
    parameter logic [7:0] DEV_ID = 8'h5A, // Arbitrary identifier value
    parameter int SLEEP_CYC = SFSR_SLEEP_ENTRY_CYC,
    parameter int WAKE_CYC = SFSR_WAKE_CYC,
    parameter int WAKE_ID_CYC = SFSR_WAKE_ID_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    sfsr_link_if.dev link,
    input wire logic cycle_busy,
    output logic [8:0] mem_addr,
    input wire logic [7:0] mem_data,
    output logic write_in_progress,
    output logic asleep,
    output logic standby
);

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        SFSR_D_OPC = 3'b000, // Receiving opcode
        SFSR_D_HDR = 3'b001, // Receiving address or dummies
        SFSR_D_DATA = 3'b010, // Sending data
        SFSR_D_TAIL = 3'b011, // Opcode done, awaiting deselect
        SFSR_D_IGN = 3'b100 // Ignoring until deselect
    } sfsr_dst_t;

    typedef enum logic [1:0] {
        SFSR_P_RUN = 2'b00, // Accepting commands
        SFSR_P_ENTER = 2'b01, // Sleep entry delay
        SFSR_P_SLEEP = 2'b10, // Deep sleep
        SFSR_P_WAKE = 2'b11 // Wake delay
    } sfsr_pwr_t;

    sfsr_dst_t st_r; // Frame state
    sfsr_pwr_t pwr_r; // Power state
    logic [2:0] cs_sy_r, sck_sy_r, si_sy_r; // Pin synchronisers
    logic sck_d_r; // Previous synced clock
    logic [7:0] sh_r; // Input shift register
    logic [2:0] bit_r; // Bit within byte
    logic [2:0] byte_r; // Header bytes received
    logic [7:0] op_r; // Latched opcode
    logic [8:0] ofs_r; // Secreg byte offset
    logic [7:0] out_r; // Output shift register
    logic so_oe_r; // Output enable
    logic [8:0] dly_r; // Power delay counter
    logic [8:0] dly_end_r; // Power delay target
    logic cs_n_s, sck_s, si_s; // Synced pins
    logic rise, fall, desel; // Link events
    logic [7:0] byte_in; // Completed byte

    assign cs_n_s = cs_sy_r[1];
    assign sck_s = sck_sy_r[1];
    assign si_s = si_sy_r[1];
    assign rise = !cs_n_s && sck_s && !sck_d_r;
    assign fall = !cs_n_s && !sck_s && sck_d_r;
    assign desel = cs_n_s && !cs_sy_r[2];
    assign byte_in = {sh_r[6:0], si_s};

    // Two-flop synchronisers; third stage only for edge finding
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cs_sy_r <= 3'b111;
            sck_sy_r <= 3'b000;
            si_sy_r <= 3'b000;
            sck_d_r <= 1'b0;
        end else begin
            cs_sy_r <= {cs_sy_r[1:0], link.cs_n};
            sck_sy_r <= {sck_sy_r[1:0], link.sck};
            si_sy_r <= {si_sy_r[1:0], link.si};
            sck_d_r <= sck_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame decoding
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= SFSR_D_OPC;
            sh_r <= 8'h0;
            bit_r <= 3'h0;
            byte_r <= 3'h0;
            op_r <= 8'h0;
            ofs_r <= SFSR_OFS_FIRST;
            out_r <= 8'h0;
            so_oe_r <= 1'b0;
        end else if (cs_n_s) begin
            st_r <= SFSR_D_OPC;
            bit_r <= 3'h0;
            byte_r <= 3'h0;
            so_oe_r <= 1'b0;
        end else if (rise) begin
            // Sample input on rising edge
            sh_r <= byte_in;
            bit_r <= bit_r + 3'h1;
            unique case (st_r)
                SFSR_D_OPC: begin
                    if (bit_r == 3'h7) begin
                        op_r <= byte_in;
                        if (pwr_r == SFSR_P_SLEEP &&
                            byte_in != SFSR_OP_WAKE_ID) begin
                            st_r <= SFSR_D_IGN;
                        end else if (pwr_r == SFSR_P_ENTER ||
                            pwr_r == SFSR_P_WAKE) begin
                            st_r <= SFSR_D_IGN;
                        end else if (cycle_busy) begin
                            st_r <= SFSR_D_IGN;
                        end else if (byte_in == SFSR_OP_SECREG_READ ||
                            byte_in == SFSR_OP_WAKE_ID) begin
                            st_r <= SFSR_D_HDR;
                        end else begin
                            st_r <= SFSR_D_TAIL;
                        end
                    end
                end
                SFSR_D_HDR: begin
                    if (bit_r == 3'h7) begin
                        byte_r <= byte_r + 3'h1;
                        // Second and third address bytes: offset bits
                        if (op_r == SFSR_OP_SECREG_READ && byte_r == 3'h1) begin
                            ofs_r[8] <= byte_in[0];
                        end
                        if (op_r == SFSR_OP_SECREG_READ && byte_r == 3'h2) begin
                            ofs_r[7:0] <= byte_in;
                        end
                        if ((op_r == SFSR_OP_SECREG_READ &&
                            byte_r == SFSR_SECREG_HDR_BYTES - 3'h2) ||
                            (op_r == SFSR_OP_WAKE_ID &&
                            byte_r == SFSR_WAKE_HDR_BYTES - 3'h2)) begin
                            st_r <= SFSR_D_DATA;
                        end
                    end
                end
                SFSR_D_TAIL: begin
                    // Extra bits cancel a sleep request
                    st_r <= SFSR_D_IGN;
                end
                default: begin
                end
            endcase
        end else if (fall && st_r == SFSR_D_DATA) begin
            // Shift out on falling edge, MSB first
            so_oe_r <= 1'b1;
            if (bit_r == 3'h0) begin
                if (op_r == SFSR_OP_SECREG_READ) begin
                    out_r <= mem_data;
                    ofs_r <= (ofs_r == SFSR_OFS_LAST) ? SFSR_OFS_FIRST :
                        ofs_r + 9'h1;
                end else begin
                    out_r <= DEV_ID;
                end
            end else begin
                out_r <= {out_r[6:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power state: sleep entry, sleep, wake delays
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pwr_r <= SFSR_P_RUN;
            dly_r <= 9'h0;
            dly_end_r <= 9'h0;
        end else begin
            unique case (pwr_r)
                SFSR_P_RUN: begin
                    // Exactly eight bits of B9h, then deselect
                    if (desel && st_r == SFSR_D_TAIL &&
                        op_r == SFSR_OP_DEEP_SLEEP && !cycle_busy) begin
                        pwr_r <= SFSR_P_ENTER;
                        dly_r <= 9'h0;
                    end
                end
                SFSR_P_ENTER: begin
                    dly_r <= dly_r + 9'h1;
                    if (dly_r >= 9'(SLEEP_CYC - 1)) begin
                        pwr_r <= SFSR_P_SLEEP;
                    end
                end
                SFSR_P_SLEEP: begin
                    if (desel && op_r == SFSR_OP_WAKE_ID &&
                        (st_r == SFSR_D_TAIL || st_r == SFSR_D_HDR ||
                        st_r == SFSR_D_DATA)) begin
                        pwr_r <= SFSR_P_WAKE;
                        dly_r <= 9'h0;
                        dly_end_r <= (st_r == SFSR_D_DATA) ?
                            9'(WAKE_ID_CYC - 1) : 9'(WAKE_CYC - 1);
                    end
                end
                SFSR_P_WAKE: begin
                    dly_r <= dly_r + 9'h1;
                    if (dly_r >= dly_end_r) begin
                        pwr_r <= SFSR_P_RUN;
                    end
                end
            endcase
        end
    end

    assign link.so = out_r[7];
    assign link.so_oe = so_oe_r;
    assign mem_addr = ofs_r;
    assign write_in_progress = cycle_busy;
    assign asleep = (pwr_r == SFSR_P_SLEEP);
    assign standby = cs_n_s && !cycle_busy && pwr_r == SFSR_P_RUN;

endmodule // sfsr_dev
`default_nettype wire

/* File: src/sfsr_pkg.sv */
// Shared constants for the serial flash command sequencer and its host.
// Assumes a single 100 MHz system clock at both ends.
package sfsr_pkg;

    // Opcodes
    localparam logic [7:0] SFSR_OP_SECREG_READ = 8'h48;
    localparam logic [7:0] SFSR_OP_DEEP_SLEEP = 8'hB9;
    localparam logic [7:0] SFSR_OP_WAKE_ID = 8'hAB;

    // Security register area geometry
    localparam int SFSR_OFS_W = 9;
    localparam logic [8:0] SFSR_OFS_LAST = 9'h1FF;
    localparam logic [8:0] SFSR_OFS_FIRST = 9'h000;

    // Byte counts of the headers
    localparam logic [2:0] SFSR_SECREG_HDR_BYTES = 3'h5;
    localparam logic [2:0] SFSR_WAKE_HDR_BYTES = 3'h4;

    // Clock rate and delays in their own unit
    localparam int SFSR_CLK_MHZ = 100;
    localparam int SFSR_SLEEP_ENTRY_NS = 3000;
    localparam int SFSR_WAKE_NS = 3000;
    localparam int SFSR_WAKE_ID_NS = 1800;
    localparam int SFSR_SLEEP_ENTRY_CYC =
        (SFSR_SLEEP_ENTRY_NS * SFSR_CLK_MHZ) / 1000;
    localparam int SFSR_WAKE_CYC = (SFSR_WAKE_NS * SFSR_CLK_MHZ + 999) / 1000;
    localparam int SFSR_WAKE_ID_CYC =
        (SFSR_WAKE_ID_NS * SFSR_CLK_MHZ + 999) / 1000;

    // Serial clock divider for the host: half period in system cycles
    localparam int SFSR_SCK_HALF_CYC = 8;

    // Host request kinds
    typedef enum logic [1:0] {
        SFSR_REQ_SECREG = 2'b00,
        SFSR_REQ_SLEEP = 2'b01,
        SFSR_REQ_WAKE = 2'b10,
        SFSR_REQ_WAKE_ID = 2'b11
    } sfsr_req_t;

endpackage : sfsr_pkg

/* File: src/sfsr_link_if.sv */
// Four-wire serial link between host controller and flash device.
// Assumes both ends share one system clock; link pins are plain wires.
`timescale 1ns/1ns
`default_nettype none
interface sfsr_link_if;
    logic cs_n; // Chip select, active low
    logic sck; // Serial clock from the host
    logic si; // Data host to device
    logic so; // Data device to host
    logic so_oe; // Device drives so while high

    modport dev (input cs_n, input sck, input si, output so, output so_oe);
    modport host (output cs_n, output sck, output si, input so, input so_oe);
endinterface : sfsr_link_if
`default_nettype wire

/* File: src/sfsr_host.sv */
// Host end: issues secreg read, deep sleep and wake commands.
// Assumes the device end on the link interface; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module sfsr_host
    import sfsr_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    sfsr_link_if.host link,
    input wire logic req_valid,
    output logic req_ready,
    input wire sfsr_req_t req_kind,
    input wire logic [8:0] req_offset,
    input wire logic [7:0] req_len,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic busy
);

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        SFSR_H_IDLE = 2'b00,
        SFSR_H_SHIFT = 2'b01,
        SFSR_H_GAP = 2'b10
    } sfsr_hst_t;

    sfsr_hst_t st_r; // Host state
    logic [3:0] div_r; // Serial clock divider
    logic sck_r; // Serial clock level
    logic cs_n_r; // Chip select level
    logic [39:0] tx_r; // Outgoing header bits
    logic [5:0] tx_left_r; // Header bits still to send
    logic [2:0] rx_cnt_r; // Bits within received byte
    logic [7:0] rx_sh_r; // Receive shift register
    logic [7:0] rx_left_r; // Bytes still to receive
    logic [8:0] gap_r; // Chip select high time counter
    logic [8:0] gap_len_r; // Required high time
    logic so_s1_r, so_s2_r; // Synchroniser for data in
    logic rd_valid_r; // Byte strobe
    logic [7:0] rd_data_r; // Last byte
    logic tick; // Half period enable
    logic rise_tick; // Next tick raises clock
    logic fall_tick; // Next tick lowers clock

    assign tick = (div_r == 4'(SFSR_SCK_HALF_CYC - 1));
    assign rise_tick = tick && !sck_r && st_r == SFSR_H_SHIFT;
    assign fall_tick = tick && sck_r;

    // Divider runs only while shifting
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_r <= 4'h0;
        end else if (st_r != SFSR_H_SHIFT || tick) begin
            div_r <= 4'h0;
        end else begin
            div_r <= div_r + 4'h1;
        end
    end

    // Data input synchroniser
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            so_s1_r <= 1'b0;
            so_s2_r <= 1'b0;
        end else begin
            so_s1_r <= link.so;
            so_s2_r <= so_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command sequencing
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= SFSR_H_IDLE;
            sck_r <= 1'b0;
            cs_n_r <= 1'b1;
            tx_r <= 40'h0;
            tx_left_r <= 6'h0;
            rx_cnt_r <= 3'h0;
            rx_sh_r <= 8'h0;
            rx_left_r <= 8'h0;
            gap_r <= 9'h0;
            gap_len_r <= 9'h0;
            rd_valid_r <= 1'b0;
            rd_data_r <= 8'h0;
        end else begin
            rd_valid_r <= 1'b0;
            unique case (st_r)
                SFSR_H_IDLE: begin
                    if (req_valid) begin
                        cs_n_r <= 1'b0;
                        st_r <= SFSR_H_SHIFT;
                        gap_len_r <= 9'(SFSR_WAKE_CYC);
                        rx_left_r <= 8'h0;
                        tx_left_r <= 6'd8;
                        unique case (req_kind)
                            SFSR_REQ_SECREG: begin
                                // Upper address bits zero, offset low
                                tx_r <= {SFSR_OP_SECREG_READ, 15'h0000,
                                    req_offset, 8'h00};
                                tx_left_r <= 6'd40;
                                rx_left_r <= req_len;
                            end
                            SFSR_REQ_SLEEP: begin
                                // Exactly eight bits, then deselect
                                tx_r <= {SFSR_OP_DEEP_SLEEP, 32'h0};
                            end
                            SFSR_REQ_WAKE: begin
                                tx_r <= {SFSR_OP_WAKE_ID, 32'h0};
                            end
                            SFSR_REQ_WAKE_ID: begin
                                tx_r <= {SFSR_OP_WAKE_ID, 32'h0};
                                tx_left_r <= 6'd32;
                                rx_left_r <= req_len;
                                gap_len_r <= 9'(SFSR_WAKE_ID_CYC);
                            end
                        endcase
                    end
                end
                SFSR_H_SHIFT: begin
                    if (rise_tick) begin
                        sck_r <= 1'b1;
                        // Receive bits, device changed them on fall
                        if (tx_left_r == 6'h0) begin
                            rx_sh_r <= {rx_sh_r[6:0], so_s2_r};
                            rx_cnt_r <= rx_cnt_r + 3'h1;
                            if (rx_cnt_r == 3'h7) begin
                                rd_valid_r <= 1'b1;
                                rd_data_r <= {rx_sh_r[6:0], so_s2_r};
                                rx_left_r <= rx_left_r - 8'h1;
                            end
                        end else begin
                            tx_left_r <= tx_left_r - 6'h1;
                        end
                    end else if (fall_tick) begin
                        sck_r <= 1'b0;
                        if (tx_left_r != 6'h0) begin
                            tx_r <= {tx_r[38:0], 1'b0};
                        end
                        if (tx_left_r == 6'h0 && rx_left_r == 8'h0) begin
                            cs_n_r <= 1'b1;
                            gap_r <= 9'h0;
                            st_r <= SFSR_H_GAP;
                        end
                    end
                end
                SFSR_H_GAP: begin
                    // Hold deselect for the wake delay
                    gap_r <= gap_r + 9'h1;
                    if (gap_r >= gap_len_r) begin
                        st_r <= SFSR_H_IDLE;
                    end
                end
                default: begin
                    st_r <= SFSR_H_IDLE;
                end
            endcase
        end
    end

    assign link.cs_n = cs_n_r;
    assign link.sck = sck_r;
    assign link.si = tx_r[39];
    assign req_ready = (st_r == SFSR_H_IDLE);
    assign rd_valid = rd_valid_r;
    assign rd_data = rd_data_r;
    assign busy = (st_r != SFSR_H_IDLE);

endmodule // sfsr_host
`default_nettype wire

/* File: bench/sfsr_checker.sv */
// Link checker: watches the four link wires between host and device.
// Assumes one clock domain; instantiated beside the link interface.
`timescale 1ns/1ns
`default_nettype none
module sfsr_checker
    import sfsr_pkg::*;
#(
    parameter logic [7:0] DEV_ID = 8'h5A // Arbitrary identifier value
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////
    logic sck_d_r; // Serial clock one cycle back
    logic [2:0] bit_r; // Bit within current byte
    logic [2:0] byte_r; // Whole bytes seen, saturating
    logic [7:0] op_r; // First byte of the frame
    wire logic sck_rise = sck & ~sck_d_r; // Rising serial clock
    // Edge finder
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) sck_d_r <= 1'b0;
        else sck_d_r <= sck;
    end
    // Frame position and opcode capture
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bit_r <= 3'h0;
            byte_r <= 3'h0;
            op_r <= 8'h00;
        end else if (cs_n) begin // Deselect clears position
            bit_r <= 3'h0;
            byte_r <= 3'h0;
        end else if (sck_rise) begin
            bit_r <= bit_r + 3'h1;
            if (bit_r == 3'h7 && byte_r != 3'h7) byte_r <= byte_r + 3'h1;
            if (byte_r == 3'h0) op_r <= {op_r[6:0], si};
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_sck_idle;
        cs_n && $past(cs_n) |-> !sck;
    endproperty
    a_sck_idle: assert property (p_sck_idle)
        else $error("serial clock moved while deselected");
    property p_si_hold;
        sck && $past(sck) |-> $stable(si);
    endproperty
    a_si_hold: assert property (p_si_hold)
        else $error("input line changed while clock high");
    property p_sck_half;
        $rose(sck) |-> sck [*8] ##1 !sck;
    endproperty
    a_sck_half: assert property (p_sck_half)
        else $error("serial clock high phase not eight cycles");
    property p_so_fall;
        so_oe && $past(so_oe) && $changed(so) |-> !sck;
    endproperty
    a_so_fall: assert property (p_so_fall)
        else $error("output changed while clock high");
    property p_so_quiet;
        cs_n [*5] |-> !so_oe;
    endproperty
    a_so_quiet: assert property (p_so_quiet)
        else $error("output driven while deselected");
    property p_so_data;
        so_oe && !cs_n && !$past(cs_n, 4) |-> byte_r >= 3'h4;
    endproperty
    a_so_data: assert property (p_so_data)
        else $error("output driven before header complete");
    property p_id_bit;
        sck_rise && so_oe && op_r == SFSR_OP_WAKE_ID && byte_r >= 3'h4
            |-> so == DEV_ID[3'h7 - bit_r];
    endproperty
    a_id_bit: assert property (p_id_bit)
        else $error("identifier bit wrong");
    property p_cs_whole;
        $rose(cs_n) |-> $past(bit_r) == 3'h0;
    endproperty
    a_cs_whole: assert property (p_cs_whole)
        else $error("deselect inside a byte");
    property p_so_release;
        $rose(cs_n) |-> ##[0:4] !so_oe;
    endproperty
    a_so_release: assert property (p_so_release)
        else $error("output not released after deselect");
    // Main scenarios seen
    c_secreg: cover property ($rose(cs_n) && $past(byte_r) >= 3'h5
        && $past(op_r) == SFSR_OP_SECREG_READ);
    c_sleep: cover property ($rose(cs_n) && $past(byte_r) == 3'h1
        && $past(op_r) == SFSR_OP_DEEP_SLEEP);
    c_id: cover property (sck_rise && so_oe && op_r == SFSR_OP_WAKE_ID);
endmodule // sfsr_checker
`default_nettype wire

/* File: bench/testbench.sv */
// Bench: host and device joined by the link, driven from the host side.
// Assumes short delay parameters; memory contents come from a pattern.
`timescale 1ns/1ns
`default_nettype none
module testbench
    import sfsr_pkg::*;
;
    localparam logic [7:0] tb_dev_id = 8'hC3; // Arbitrary identifier value
    localparam int slp = 40; // Shortened entry delay
    localparam int wk = 30; // Shortened wake delay
    localparam int wkid = 20; // Shortened wake with id delay
    logic clk, nrst, req_valid, req_ready, rd_valid, busy, cycle_busy;
    logic write_in_progress, asleep, standby;
    sfsr_req_t req_kind; // Request kind
    logic [8:0] req_offset, mem_addr;
    logic [7:0] req_len, rd_data, mem_data;
    logic cs_q; // Chip select one cycle back
    int fails, tests_run, since, oe_cnt, k;
    integer seed, r;
    logic [7:0] got[$]; // Bytes of the last request
    ////////////////////////////////////////////////////////////////////////
    // Memory pattern
    function automatic logic [7:0] mem_pat(input logic [8:0] a);
        return a[7:0] ^ {a[8], 7'h2B};
    endfunction
    assign mem_data = mem_pat(mem_addr);
    sfsr_link_if sfsr_link_if_i ();
    sfsr_host sfsr_host_i (.clk(clk), .nrst(nrst), .link(sfsr_link_if_i),
        .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind),
        .req_offset(req_offset), .req_len(req_len), .rd_valid(rd_valid),
        .rd_data(rd_data), .busy(busy));
    sfsr_dev #(.DEV_ID(tb_dev_id), .SLEEP_CYC(slp), .WAKE_CYC(wk),
        .WAKE_ID_CYC(wkid)) sfsr_dev_i (.clk(clk), .nrst(nrst),
        .link(sfsr_link_if_i), .cycle_busy(cycle_busy), .mem_addr(mem_addr),
        .mem_data(mem_data), .write_in_progress(write_in_progress),
        .asleep(asleep), .standby(standby));
    sfsr_checker #(.DEV_ID(tb_dev_id)) sfsr_checker_i (.clk(clk),
        .nrst(nrst), .cs_n(sfsr_link_if_i.cs_n), .sck(sfsr_link_if_i.sck),
        .si(sfsr_link_if_i.si), .so(sfsr_link_if_i.so),
        .so_oe(sfsr_link_if_i.so_oe));
    ////////////////////////////////////////////////////////////////////////
    // Clock
    initial clk = 1'b0;
    always #5 clk = ~clk;
    // Cycles from deselect to sleep, and cycles with output driven
    always @(posedge clk) begin
        cs_q <= sfsr_link_if_i.cs_n;
        if (sfsr_link_if_i.cs_n && !cs_q) since <= 0;
        else if (!asleep) since <= since + 1;
        if (sfsr_link_if_i.so_oe) oe_cnt <= oe_cnt + 1;
    end
    task automatic check(input string name, input logic [15:0] seen,
        input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("Checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic timeout;
        fails++;
        $display("Error wait expected done seen stuck");
        finish_test();
    endtask
    // One host request, collecting returned bytes
    task automatic do_req(input sfsr_req_t kd, input logic [8:0] off,
        input logic [7:0] len);
        int n;
        got.delete();
        @(negedge clk);
        req_kind = kd;
        req_offset = off;
        req_len = len;
        req_valid = 1'b1;
        for (n = 0; !req_ready; n++) begin
            if (n > 1000) timeout();
            @(negedge clk);
        end
        @(negedge clk);
        req_valid = 1'b0;
        for (n = 0; busy; n++) begin
            if (rd_valid) got.push_back(rd_data);
            if (n > 20000) timeout();
            @(negedge clk);
        end
        repeat (3) begin
            if (rd_valid) got.push_back(rd_data);
            @(negedge clk);
        end
    endtask
    // Security read with data comparison
    task automatic rd_check(input logic [8:0] off, input logic [7:0] len);
        do_req(SFSR_REQ_SECREG, off, len);
        check("count", 16'(got.size()), 16'(len));
        foreach (got[i]) check("secreg", 16'(got[i]),
            16'(mem_pat(off + 9'(i))));
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {nrst, req_valid, cycle_busy, fails, tests_run, since, oe_cnt} = '0;
        {req_offset, req_len} = '0;
        req_kind = SFSR_REQ_SECREG;
        seed = 32'h1746;
        wait_cyc(16);
        check("asleep", 16'(asleep), 16'h0000);
        nrst = 1'b1;
        wait_cyc(2);
        check("standby", 16'(standby), 16'h0001);
        rd_check(9'h1FE, 8'h04);
        rd_check(9'h000, 8'h00);
        for (k = 0; k < 6; k++) begin
            r = $random(seed);
            rd_check(r[8:0], 8'(r[11:9]) + 8'h01);
        end
        do_req(SFSR_REQ_WAKE_ID, 9'h000, 8'h03);
        check("id_count", 16'(got.size()), 16'h0003);
        foreach (got[i]) check("id", 16'(got[i]), 16'(tb_dev_id));
        cycle_busy = 1'b1;
        wait_cyc(4);
        check("wip", 16'(write_in_progress), 16'h0001);
        check("standby_busy", 16'(standby), 16'h0000);
        do_req(SFSR_REQ_SLEEP, 9'h000, 8'h00);
        wait_cyc(slp + 20);
        check("asleep_busy", 16'(asleep), 16'h0000);
        cycle_busy = 1'b0;
        wait_cyc(4);
        check("wip_done", 16'(write_in_progress), 16'h0000);
        do_req(SFSR_REQ_SLEEP, 9'h000, 8'h00);
        for (k = 0; !asleep; k++) begin
            if (k > 500) timeout();
            @(negedge clk);
        end
        check("entry_min", 16'(since >= slp), 16'h0001);
        check("entry_max", 16'(since <= slp + 8), 16'h0001);
        oe_cnt = 0;
        do_req(SFSR_REQ_SECREG, 9'h005, 8'h02);
        check("oe_asleep", 16'(oe_cnt), 16'h0000);
        check("asleep_read", 16'(asleep), 16'h0001);
        cycle_busy = 1'b1;
        do_req(SFSR_REQ_WAKE, 9'h000, 8'h00);
        wait_cyc(wk + 20);
        check("wake_busy", 16'(asleep), 16'h0001);
        cycle_busy = 1'b0;
        do_req(SFSR_REQ_WAKE, 9'h000, 8'h00);
        wait_cyc(wk + 20);
        check("woken", 16'(asleep), 16'h0000);
        rd_check(9'h1FF, 8'h02);
        do_req(SFSR_REQ_SLEEP, 9'h000, 8'h00);
        wait_cyc(slp + 20);
        do_req(SFSR_REQ_WAKE_ID, 9'h000, 8'h01);
        wait_cyc(wkid + 20);
        check("woken_id", 16'(asleep), 16'h0000);
        rd_check(9'h0A7, 8'h03);
        finish_test();
    end
endmodule // testbench
`default_nettype wire
